// ==== hw/sdmi_indexer.sv ====
// How it works
// - Dual edge bit selects rising or both
// - Direction sampled on each active edge
// - Fullstep or 2..256 microsteps selectable
// - Direction low counts up, high down
// - Counter indexes sine and cosine table
// - Ramp generator idle while the bypass strap is high
// - Interpolate microsteps between incoming steps
// - Bypass strap low in host mode: internal ramp positioning
// - Host mode gives control and feedback
// - Standalone mode takes configuration from pins
// - Bypass strap routes step source in host mode
//
// The implementer's own choices: the address map and the APB register port.
module sdmi_indexer
  import sdmi_pkg::*;
(
  // Clock, synchronous reset and clock enable.
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Asynchronous pins from the motion controller and straps.
  input wire logic stepPin,
  input wire logic dirPin,
  input wire logic rampBypassStrap,
  input wire logic hostSelStrap,
  // Standalone configuration pins.
  input wire logic [3:0] cfgMres,
  input wire logic cfgDedge,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Coil currents and chopper setting.
  output sdmi_coil_t coil,
  output logic [7:0] chopCfg
);

  // Three-stage pin synchronisers; stage one feeds only stage two.
  logic [2:0] stepSync_ff;
  logic [2:0] dirSync_ff;
  logic [2:0] bypSync_ff;
  logic [2:0] hostSync_ff;
  // Filtered pin levels, updated when stages two and three agree.
  logic stepLvl_ff;
  logic dirLvl_ff;
  sdmi_strap_t strap_ff;

  // Registers.
  logic [31:0] ctrl_ff;
  logic [31:0] target_ff;
  logic [15:0] rate_ff;
  logic [7:0] chop_ff;
  logic [31:0] pos_ff;
  logic [CNT_W-1:0] cnt_ff;
  // Interpolator state.
  logic [15:0] perCnt_ff;
  logic [15:0] perEst_ff;
  logic [15:0] subCnt_ff;
  logic [7:0] subLeft_ff;
  logic subDir_ff;
  // Ramp generator state.
  sdmi_ramp_t ramp_ff;
  logic [15:0] rampCnt_ff;

  // Effective configuration and derived events.
  logic [3:0] mres;
  logic dedge;
  logic intpol;
  logic stepEdge;
  logic [CNT_W-1:0] stepSize;
  logic [7:0] subSteps;
  logic rampStep;
  logic rampDir;
  logic ipStep;
  logic [7:0] sinAddr;
  logic [7:0] cosAddr;
  logic [8:0] sinMag;
  logic [8:0] cosMag;
  logic [1:0] quadPipe_ff;
  logic apbAcc;

  // Sample each pin through three flops.
  always_ff @(posedge clk) begin
    if (rst) begin
      stepSync_ff <= 3'h0;
      dirSync_ff <= 3'h0;
      bypSync_ff <= 3'h0;
      hostSync_ff <= 3'h0;
    end else if (ce) begin
      stepSync_ff <= {stepSync_ff[1:0], stepPin};
      dirSync_ff <= {dirSync_ff[1:0], dirPin};
      bypSync_ff <= {bypSync_ff[1:0], rampBypassStrap};
      hostSync_ff <= {hostSync_ff[1:0], hostSelStrap};
    end
  end

  // Accept a level only once the last two stages agree.
  always_ff @(posedge clk) begin
    if (rst) begin
      stepLvl_ff <= 1'b0;
      dirLvl_ff <= 1'b0;
      strap_ff <= '{rampBypass: 1'b1, hostSel: 1'b1};
    end else if (ce) begin
      if (stepSync_ff[1] == stepSync_ff[2]) begin
        stepLvl_ff <= stepSync_ff[2];
      end
      if (dirSync_ff[1] == dirSync_ff[2]) begin
        dirLvl_ff <= dirSync_ff[2];
      end
      if (bypSync_ff[1] == bypSync_ff[2]) begin
        strap_ff.rampBypass <= bypSync_ff[2];
      end
      if (hostSync_ff[1] == hostSync_ff[2]) begin
        strap_ff.hostSel <= hostSync_ff[2];
      end
    end
  end

  // Configuration source depends on the host strap.
  always_comb begin
    if (!strap_ff.hostSel) begin
      mres = cfgMres;
      dedge = cfgDedge;
      intpol = 1'b1;
    end else begin
      mres = ctrl_ff[CTRL_MRES_LSB +: 4];
      dedge = ctrl_ff[CTRL_DEDGE_BIT];
      intpol = ctrl_ff[CTRL_INTPOL_BIT];
    end
    // Codes above fullstep behave as fullstep.
    if (mres > MRES_FULL) begin
      mres = MRES_FULL;
    end
  end

  // Active edge detection on the filtered step level.
  always_comb begin
    stepEdge = stepSync_ff[1] == stepSync_ff[2] &&
               stepSync_ff[2] != stepLvl_ff &&
               (dedge || stepSync_ff[2]);
  end

  assign stepSize = CNT_W'(1) << mres;
  assign subSteps = 8'(stepSize - CNT_W'(1));

  // Internal ramp only runs when the bypass strap is low.
  // step source
  assign rampStep = !strap_ff.rampBypass && strap_ff.hostSel &&
                    ctrl_ff[CTRL_HOSTRUN_BIT] && ramp_ff == SDMI_R_RUN &&
                    rampCnt_ff == 16'h0000;
  assign rampDir = $signed(target_ff - pos_ff) < 0;
  // Interpolated single microstep inside the current step window.
  assign ipStep = subLeft_ff != 8'h00 && subCnt_ff == 16'h0000;

  // Bus accepts every request on its access cycle.
  assign apbAcc = psel && penable;

  // APB writes to the configuration registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_ff <= CTRL_RST;
      target_ff <= TARGET_RST;
      rate_ff <= RATE_RST;
      chop_ff <= CHOP_RST;
    end else if (ce && apbAcc && pwrite) begin
      unique case (paddr)
        OFS_CTRL: ctrl_ff <= {25'h0, pwdata[6:0]};
        OFS_TARGET: target_ff <= pwdata;
        OFS_RATE: rate_ff <= pwdata[15:0];
        OFS_CHOP: chop_ff <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // APB read data, ready and error.
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        pslverr <= !(paddr inside {OFS_CTRL, OFS_STAT, OFS_CNT, OFS_CUR,
                                   OFS_TARGET, OFS_RATE, OFS_CHOP});
        unique case (paddr)
          OFS_CTRL: prdata <= ctrl_ff;
          OFS_STAT: prdata <= {28'h0, ramp_ff, strap_ff};
          OFS_CNT: prdata <= {22'h0, cnt_ff};
          OFS_CUR: prdata <= {7'h0, coil.coilA, 7'h0, coil.coilB};
          OFS_TARGET: prdata <= target_ff;
          OFS_RATE: prdata <= {16'h0, rate_ff};
          OFS_CHOP: prdata <= {24'h0, chop_ff};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // Microstep counter and position.
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= '0;
      pos_ff <= 32'h0;
    end else if (ce) begin
      if (strap_ff.rampBypass || !strap_ff.hostSel) begin
        if (stepEdge) begin
          if (!intpol) begin
            cnt_ff <= dirLvl_ff ? cnt_ff - stepSize : cnt_ff + stepSize;
          end else begin
            // Jump to the end of any unfinished window, then one microstep.
            cnt_ff <= dirLvl_ff ?
              cnt_ff - CNT_W'(subLeft_ff) - CNT_W'(1) :
              cnt_ff + CNT_W'(subLeft_ff) + CNT_W'(1);
          end
          pos_ff <= dirLvl_ff ? pos_ff - 32'h1 : pos_ff + 32'h1;
        end else if (ipStep) begin
          cnt_ff <= subDir_ff ? cnt_ff - CNT_W'(1) : cnt_ff + CNT_W'(1);
        end
      end else if (rampStep) begin
        cnt_ff <= rampDir ? cnt_ff - stepSize : cnt_ff + stepSize;
        pos_ff <= rampDir ? pos_ff - 32'h1 : pos_ff + 32'h1;
      end
    end
  end

  // Step period measurement and sub-step timing.
  always_ff @(posedge clk) begin
    if (rst) begin
      perCnt_ff <= 16'h0;
      perEst_ff <= PER_MAX;
      subCnt_ff <= 16'h0;
      subLeft_ff <= 8'h0;
      subDir_ff <= 1'b0;
    end else if (ce) begin
      if (perCnt_ff != PER_MAX) begin
        perCnt_ff <= perCnt_ff + 16'h1;
      end
      if (stepEdge) begin
        // The last period predicts the next; spacing is period / steps.
        perCnt_ff <= 16'h0;
        perEst_ff <= perCnt_ff;
        subCnt_ff <= perCnt_ff >> mres;
        // No window opens without interpolation or for an ignored step.
        if (intpol && (strap_ff.rampBypass || !strap_ff.hostSel)) begin
          subLeft_ff <= subSteps;
        end else begin
          subLeft_ff <= 8'h00;
        end
        subDir_ff <= dirLvl_ff;
      end else if (subLeft_ff != 8'h00) begin
        if (subCnt_ff == 16'h0000) begin
          subCnt_ff <= perEst_ff >> mres;
          subLeft_ff <= subLeft_ff - 8'h1;
        end else begin
          subCnt_ff <= subCnt_ff - 16'h1;
        end
      end
    end
  end

  // Ramp generator: fixed rate steps until position meets target.
  always_ff @(posedge clk) begin
    if (rst) begin
      ramp_ff <= SDMI_R_IDLE;
      rampCnt_ff <= 16'h0;
    end else if (ce) begin
      unique case (ramp_ff)
        SDMI_R_IDLE: begin
          if (!strap_ff.rampBypass && ctrl_ff[CTRL_HOSTRUN_BIT] &&
              pos_ff != target_ff) begin
            ramp_ff <= SDMI_R_RUN;
            rampCnt_ff <= rate_ff;
          end
        end
        SDMI_R_RUN: begin
          if (strap_ff.rampBypass || pos_ff == target_ff) begin
            ramp_ff <= SDMI_R_DONE;
          end else if (rampCnt_ff == 16'h0000) begin
            rampCnt_ff <= rate_ff;
          end else begin
            rampCnt_ff <= rampCnt_ff - 16'h1;
          end
        end
        SDMI_R_DONE: begin
          ramp_ff <= SDMI_R_IDLE;
        end
        default: ramp_ff <= SDMI_R_IDLE;
      endcase
    end
  end

  // table lookup
  // Quarter addressing: sine mirrors in odd quarters and negates in the upper half; cosine mirrors in even quarters.
  assign sinAddr = cnt_ff[8] ? ~cnt_ff[7:0] : cnt_ff[7:0];
  assign cosAddr = cnt_ff[8] ? cnt_ff[7:0] : ~cnt_ff[7:0];

  sdmi_sine_rom uSin (
    .clk(clk),
    .ce(ce),
    .addr(sinAddr),
    .mag(sinMag)
  );

  sdmi_sine_rom uCos (
    .clk(clk),
    .ce(ce),
    .addr(cosAddr),
    .mag(cosMag)
  );

  // Sign bits are registered together with the table read, so both line up.
  always_ff @(posedge clk) begin
    if (rst) begin
      quadPipe_ff <= 2'h0;
    end else if (ce) begin
      quadPipe_ff <= cnt_ff[9:8];
    end
  end

  // Coil outputs, one cycle after the table.
  always_ff @(posedge clk) begin
    if (rst) begin
      coil <= '{coilA: 9'h000, coilB: CUR_PEAK};
    end else if (ce) begin
      coil.coilA <= quadPipe_ff[1] ? -$signed(sinMag) : $signed(sinMag);
      coil.coilB <= (quadPipe_ff == 2'h1 || quadPipe_ff == 2'h2) ?
                    -$signed(cosMag) : $signed(cosMag);
    end
  end

  // Chopper setting comes from the host or a fixed default standalone.
  always_ff @(posedge clk) begin
    if (rst) begin
      chopCfg <= CHOP_RST;
    end else if (ce) begin
      chopCfg <= strap_ff.hostSel ? chop_ff : CHOP_RST;
    end
  end

endmodule

// ==== hw/sdmi_pkg.sv ====
package sdmi_pkg;

  // Width of the microstep counter; one electrical period is 1024 microsteps.
  localparam int CNT_W = 10;
  // Signed width of each coil current word.
  localparam int CUR_W = 9;
  // Peak coil current value at the top of the sine wave.
  localparam logic [8:0] CUR_PEAK = 9'h0f8;
  // Number of entries in the quarter-wave table.
  localparam int QTR_N = 256;

  // Resolution codes: 0 = 256 microsteps per fullstep ... 8 = fullstep.
  localparam logic [3:0] MRES_RST = 4'h0;
  localparam logic [3:0] MRES_FULL = 4'h8;

  // Register byte offsets on the APB bus.
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STAT = 12'h004;
  localparam logic [11:0] OFS_CNT = 12'h008;
  localparam logic [11:0] OFS_CUR = 12'h00c;
  localparam logic [11:0] OFS_TARGET = 12'h010;
  localparam logic [11:0] OFS_RATE = 12'h014;
  localparam logic [11:0] OFS_CHOP = 12'h018;

  // Control register field positions.
  localparam int CTRL_MRES_LSB = 0;
  localparam int CTRL_DEDGE_BIT = 4;
  localparam int CTRL_INTPOL_BIT = 5;
  localparam int CTRL_HOSTRUN_BIT = 6;

  // Reset values of the writable registers.
  localparam logic [31:0] CTRL_RST = 32'h0000_0020;
  localparam logic [31:0] TARGET_RST = 32'h0000_0000;
  localparam logic [15:0] RATE_RST = 16'h0064;
  localparam logic [7:0] CHOP_RST = 8'h10;

  // Interpolation: the step period estimate saturates at this many cycles.
  localparam logic [15:0] PER_MAX = 16'hffff;

  // Ramp generator state encoding, Gray along idle, run, done.
  typedef enum logic [1:0] {
    SDMI_R_IDLE = 2'b00,
    SDMI_R_RUN = 2'b01,
    SDMI_R_DONE = 2'b11
  } sdmi_ramp_t;

  // Pair of coil current words that travel together.
  typedef struct packed {
    logic signed [8:0] coilA;
    logic signed [8:0] coilB;
  } sdmi_coil_t;

  // Mode strap pair as seen after synchronisation.
  typedef struct packed {
    logic rampBypass;
    logic hostSel;
  } sdmi_strap_t;

endpackage

// ==== hw/sdmi_sine_rom.sv ====
module sdmi_sine_rom
  import sdmi_pkg::*;
(
  // Clock and enable.
  input wire logic clk,
  input wire logic ce,
  // Quarter-wave address and registered magnitude.
  input wire logic [7:0] addr,
  output logic [8:0] mag
);

  // Quarter wave table built at elaboration, so no file is read.
  logic [8:0] table_c [QTR_N];

  // Fixed-point sine via a parabola pair; exact shape is not critical.
  function automatic logic [8:0] sineAt(int i);
    int x;
    int y;
    x = (i * 2) + 1;
    y = (x * (1024 - x));
    // One above the peak, so the last entry rounds down onto the peak.
    y = (y * (int'(CUR_PEAK) + 1)) / (512 * 512);
    y = y + ((y * (248 - y)) / 1024);
    if (y > 248) begin
      y = 248;
    end
    return 9'(y);
  endfunction

  // Table contents are constant.
  always_comb begin
    for (int i = 0; i < QTR_N; i++) begin
      table_c[i] = sineAt(i);
    end
  end

  // Read data comes out of a register.
  always_ff @(posedge clk) begin
    if (ce) begin
      mag <= table_c[addr];
    end
  end

endmodule

// ==== dv/sdmi_indexer_asserts.sv ====
module sdmi_indexer_asserts
  import sdmi_pkg::*;
(
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Pins and straps.
  input wire logic stepPin,
  input wire logic dirPin,
  input wire logic rampBypassStrap,
  input wire logic hostSelStrap,
  input wire logic [3:0] cfgMres,
  input wire logic cfgDedge,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Outputs toward the power stage.
  input wire sdmi_coil_t coil,
  input wire logic [7:0] chopCfg
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Setup phase of a transfer while the block is clocked.
  logic setupCyc;
  assign setupCyc = psel && !penable && ce;

  a_ready_setup: assert property (
    setupCyc |=> pready) else $error("no pready after setup");
  a_ready_pulse: assert property (
    pready |=> !pready) else $error("pready held two cycles");
  a_err_ready: assert property (
    pslverr |-> pready) else $error("pslverr without pready");
  a_unmapped_err: assert property (
    setupCyc && paddr > OFS_CHOP |=> pready && pslverr)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (
    setupCyc && paddr <= OFS_CHOP && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped access refused");
  a_err_zero: assert property (
    pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_reset_out: assert property (
    $fell(rst) |-> coil == {9'h000, CUR_PEAK} && chopCfg == CHOP_RST)
    else $error("outputs not at reset values");
  // Straps must stay put long enough to clear the synchronisers.
  a_chop_write: assert property (
    hostSelStrap[*6] ##0 (psel && penable && pwrite && ce
    && paddr == OFS_CHOP) |-> ##2 chopCfg == 8'($past(pwdata, 2)))
    else $error("chopper setting not written");
  a_stat_straps: assert property (
    ($stable(rampBypassStrap) && $stable(hostSelStrap))[*6]
    ##0 (setupCyc && !pwrite && paddr == OFS_STAT)
    |=> prdata[1:0] == {$past(rampBypassStrap), $past(hostSelStrap)})
    else $error("status straps wrong");
endmodule

bind sdmi_indexer sdmi_indexer_asserts u_chk (.clk, .rst, .ce, .stepPin,
  .dirPin, .rampBypassStrap, .hostSelStrap, .cfgMres, .cfgDedge, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .coil,
  .chopCfg);

// ==== dv/sdmi_step_src.sv ====
module sdmi_step_src
(
  // Clock of the motion controller.
  input wire logic clk,
  // Step and direction lines toward the block.
  output logic stepPin,
  output logic dirPin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Lines rest low, so the first edge sent is a rising one.
  initial begin
    stepPin = 1'b0;
    dirPin = 1'b0;
  end
  // direction held around edges.
  // Direction settles four cycles ahead and holds through the level.
  task automatic edgeOut(input logic dir, input int hold);
    dirPin <= dir;
    repeat (4) @(posedge clk);
    stepPin <= ~stepPin;
    repeat (hold) @(posedge clk);
  endtask
  // One whole pulse; a long gap models a slow controller.
  task automatic pulse(input logic dir, input int gap);
    edgeOut(dir, 3);
    edgeOut(dir, gap);
  endtask
endmodule

// ==== dv/sdmi_indexer_bench.sv ====
`define CHK(nm, e, g) \
  begin \
    compares++; \
    if ((g) !== (e)) begin \
      errorCnt++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
    end \
  end

module sdmi_indexer_bench
  import sdmi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Block inputs and outputs.
  logic clk, rst, ce, rampBypassStrap, hostSelStrap, cfgDedge;
  logic [3:0] cfgMres;
  logic psel, penable, pwrite, pready, pslverr, stepPin, dirPin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdVal;
  sdmi_coil_t coil;
  logic [7:0] chopCfg;
  // Bookkeeping.
  int errorCnt = 0;
  int compares = 0;
  int cyc = 0;
  logic rdErr;
  logic [9:0] expCnt;

  sdmi_indexer dut (.clk, .rst, .ce, .stepPin, .dirPin, .rampBypassStrap,
    .hostSelStrap, .cfgMres, .cfgDedge, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .coil, .chopCfg);
  sdmi_step_src src (.clk, .stepPin, .dirPin);

  // Free running clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // One APB transfer; waits on pready, the watchdog ends a hang.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdVal = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdChk(input logic [11:0] a, input logic [31:0] e,
                       input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rdVal)
  endtask

  task automatic testDone();
    $display("errors %0d compares %0d", errorCnt, compares);
    if (errorCnt == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog: the whole run needs well under this many cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errorCnt++;
      testDone();
    end
  end

  initial begin
    int m;
    rst = 1'b1;
    ce = 1'b1;
    rampBypassStrap = 1'b1;
    hostSelStrap = 1'b1;
    cfgMres = MRES_FULL;
    cfgDedge = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    expCnt = 10'h000;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("coil", {9'h000, CUR_PEAK}, coil)
    rdChk(OFS_CTRL, CTRL_RST, "ctrl");
    rdChk(OFS_RATE, {16'h0, RATE_RST}, "rate");
    rdChk(OFS_CHOP, {24'h0, CHOP_RST}, "chop");
    rdChk(OFS_STAT, 32'h3, "stat");
    rdChk(12'h01c, 32'h0, "unmapped");
    `CHK("slverr", 1'b1, rdErr)
    apb(1'b1, OFS_CHOP, 32'h5a);
    @(posedge clk);
    `CHK("chopCfg", 8'h5a, chopCfg)
    for (int i = 0; i < 18; i++) begin
      m = (i < 9) ? i : 17 - i;
      apb(1'b1, OFS_CTRL, 32'(m));
      src.pulse(i >= 9, 8);
      expCnt = (i < 9) ? expCnt + 10'(1 << m) : expCnt - 10'(1 << m);
      rdChk(OFS_CNT, 32'(expCnt), "cnt");
    end
    apb(1'b1, OFS_CTRL, 32'h8);
    src.pulse(1'b1, 8);
    rdChk(OFS_CNT, 32'h300, "cnt wrap");
    `CHK("coil 768", {-CUR_PEAK, 9'h000}, coil)
    src.pulse(1'b0, 8);
    src.pulse(1'b0, 8);
    `CHK("coil 256", {CUR_PEAK, 9'h000}, coil)
    apb(1'b1, OFS_CTRL, 32'h18);
    src.pulse(1'b0, 8);
    rdChk(OFS_CNT, 32'h300, "cnt dual");
    apb(1'b1, OFS_CTRL, 32'h28);
    repeat (3) src.pulse(1'b0, 20);
    repeat (400) @(posedge clk);
    rdChk(OFS_CNT, 32'h200, "cnt interp");
    apb(1'b1, OFS_TARGET, 32'h3);
    apb(1'b1, OFS_RATE, 32'h4);
    apb(1'b1, OFS_CTRL, 32'h48);
    repeat (60) @(posedge clk);
    rdChk(OFS_CNT, 32'h200, "cnt no ramp");
    rampBypassStrap <= 1'b0;
    src.pulse(1'b1, 60);
    rdChk(OFS_CNT, 32'h300, "cnt ramp");
    rdChk(OFS_STAT, 32'h1, "stat ramp");
    rampBypassStrap <= 1'b1;
    hostSelStrap <= 1'b0;
    cfgDedge <= 1'b1;
    repeat (8) @(posedge clk);
    src.pulse(1'b0, 400);
    `CHK("coil alone", {CUR_PEAK, 9'h000}, coil)
    testDone();
  end
endmodule
